//--- core/tmr8_counter.v
// 8-bit timer/counter with two compare units and a classic Wishbone slave
`include "tmr8_consts.vh"

// Operation
// - Bottom indicated when count equals zero
// - Max indicated when count equals 0xFF
// - Top is 0xFF or compare A per mode
// - Tick from prescaler or external pin edge
// - Each tick clears, increments or decrements count
// - Software count write beats any count action
// - Three-bit mode split over control A, B
// - Comparators match count against A and B
// - Match sets compare flag on next tick
// - Enabled flag raises request; service clears it
// - Writing one clears a flag bit
// - Requests visible in flags, masked individually
// - Overflow flag set by mode dependent condition
// - Compare registers double buffered only in PWM
// - Buffer moves to active at top
// - Software reaches buffer or active register
// - Wave outputs derived from match and bottom
// - Force strobe acts like match in non-PWM
// - Forced compare leaves flags and counter alone
// - Count write blocks matches on next tick
// - Timer held off until power-off bit cleared
// - Normal mode wraps, overflow when count hits zero
// - Mode 2 clears count on compare A match
// - Output mode zero leaves wave state unchanged
// - Reset clears both wave output states
module tmr8_counter (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [4:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   input wire ext_count_i,
   input wire ovf_service_i,
   input wire cmpa_service_i,
   input wire cmpb_service_i,
   output wire ovf_irq_o,
   output wire cmpa_irq_o,
   output wire cmpb_irq_o,
   output wire wave_output_a_o,
   output wire wave_output_b_o,
   output wire wave_a_en_o,
   output wire wave_b_en_o
);

   // Bus state
   reg ack_q;                  // Single-cycle acknowledge
   wire req;                   // Fresh request this cycle
   wire wr;                    // Write taken this cycle
   wire [2:0] idx;             // Register index
   // Registers
   reg [7:0] ctrl_a_q;         // Modes for both units, low mode bits
   reg [4:0] ctrl_b_q;         // Clock select and high mode bit
   reg [7:0] count_q;          // Counter value
   reg [7:0] cmp_a_q;          // Active compare A
   reg [7:0] cmp_b_q;          // Active compare B
   reg [7:0] buf_a_q;          // Buffered compare A
   reg [7:0] buf_b_q;          // Buffered compare B
   reg [2:0] flag_q;           // Overflow, compare A, compare B
   reg [2:0] mask_q;           // Interrupt enables
   reg power_off_q;            // Module held off while set
   reg wave_a_q;               // Internal wave state A
   reg wave_b_q;               // Internal wave state B
   reg dir_down_q;             // Counting direction
   reg block_q;                // Match blocking after count write
   // Prescaler and external pin
   reg [`TMR8_PRE_W-1:0] pre_q;
   reg ext_s1_q;               // Synchroniser stage one
   reg ext_s2_q;               // Synchroniser stage two
   reg ext_s3_q;               // Edge history
   // Decoded control
   wire [2:0] wgm;
   wire [2:0] cs;
   wire pwm;
   wire pc_mode;
   wire [7:0] top_val;
   reg tick;
   wire is_bottom;
   wire is_max;
   wire is_top;
   wire match_a;
   wire match_b;
   wire ovf_set;
   wire upd_pt;                // Double buffer update point
   wire cnt_wr;
   wire ca_wr;
   wire cb_wr;
   reg [7:0] count_d;
   reg dir_d;

   // Bus decode: one word per register, ack one cycle after request
   assign req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr = req & wb_we_i & wb_sel_i[0];
   assign idx = wb_adr_i[4:2];
   assign wb_ack_o = ack_q;
   assign cnt_wr = wr & (idx == `TMR8_IDX_COUNT);
   assign ca_wr = wr & (idx == `TMR8_IDX_CMP_A);
   assign cb_wr = wr & (idx == `TMR8_IDX_CMP_B);

   // Mode field split over the two controls
   assign wgm = {ctrl_b_q[`TMR8_CB_WGM_HI], ctrl_a_q[`TMR8_CA_WGM_LO]};
   assign cs = ctrl_b_q[`TMR8_CB_CS];
   assign pwm = (wgm != `TMR8_WGM_NORMAL) & (wgm != `TMR8_WGM_CTC);
   assign pc_mode = (wgm == `TMR8_WGM_PC_MAX) | (wgm == `TMR8_WGM_PC_CMPA);

   // Extremes of the count
   assign is_bottom = (count_q == `TMR8_BOTTOM);
   assign is_max = (count_q == `TMR8_MAX);
   assign top_val = (wgm == `TMR8_WGM_PC_CMPA || wgm == `TMR8_WGM_FAST_CMPA || wgm == `TMR8_WGM_CTC) ?
                    cmp_a_q : `TMR8_MAX;
   assign is_top = (count_q == top_val);

   // Comparators, gated by blocking after count write
   assign match_a = (count_q == cmp_a_q) & ~block_q;
   assign match_b = (count_q == cmp_b_q) & ~block_q;

   // Overflow condition per mode
   assign ovf_set = tick & (pc_mode ? (is_bottom & dir_down_q) :
                    (wgm == `TMR8_WGM_NORMAL || wgm == `TMR8_WGM_CTC) ? is_max : is_top);
   // Buffer update at the top of the sequence in every PWM mode
   assign upd_pt = tick & pwm & is_top;

   // Prescaler and synchronised external pin
   always @(posedge clk_i) begin
      if (rst_i) begin
         pre_q <= {`TMR8_PRE_W{1'b0}};
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         pre_q <= power_off_q ? {`TMR8_PRE_W{1'b0}} : pre_q + {{(`TMR8_PRE_W-1){1'b0}}, 1'b1};
         ext_s1_q <= ext_count_i;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // Tick selection
   always @* begin
      tick = 1'b0;
      if (power_off_q) begin
         tick = 1'b0;
      end else begin
         case (cs)
            `TMR8_CS_OFF: tick = 1'b0;
            `TMR8_CS_DIV1: tick = 1'b1;
            `TMR8_CS_DIV8: tick = &pre_q[`TMR8_PRE_8];
            `TMR8_CS_DIV64: tick = &pre_q[`TMR8_PRE_64];
            `TMR8_CS_DIV256: tick = &pre_q[`TMR8_PRE_256];
            `TMR8_CS_DIV1024: tick = &pre_q[`TMR8_PRE_1024];
            `TMR8_CS_EXT_FALL: tick = ext_s3_q & ~ext_s2_q;
            default: tick = ext_s2_q & ~ext_s3_q;
         endcase
      end
   end

   // Next count and direction
   always @* begin
      count_d = count_q;
      dir_d = dir_down_q;
      if (tick) begin
         if (pc_mode) begin
            if (is_top) begin
               dir_d = 1'b1;
            end else if (is_bottom) begin
               dir_d = 1'b0;
            end
            count_d = (dir_d) ? count_q - `TMR8_ONE : count_q + `TMR8_ONE;
            if (is_top && top_val == `TMR8_BOTTOM) begin
               count_d = `TMR8_BOTTOM;
            end
         end else if (wgm != `TMR8_WGM_NORMAL && is_top) begin
            count_d = `TMR8_BOTTOM;
            dir_d = 1'b0;
         end else begin
            count_d = count_q + `TMR8_ONE;
            dir_d = 1'b0;
         end
      end
      if (cnt_wr) begin
         count_d = wb_dat_i[7:0];
      end
   end

   // Counter, direction and blocking
   always @(posedge clk_i) begin
      if (rst_i) begin
         count_q <= `TMR8_BOTTOM;
         dir_down_q <= 1'b0;
         block_q <= 1'b0;
      end else begin
         count_q <= count_d;
         dir_down_q <= dir_d;
         // Block lasts until the next tick consumes it
         if (cnt_wr) begin
            block_q <= 1'b1;
         end else if (tick) begin
            block_q <= 1'b0;
         end
      end
   end

   // Compare registers: direct or buffered
   always @(posedge clk_i) begin
      if (rst_i) begin
         cmp_a_q <= `TMR8_BOTTOM;
         cmp_b_q <= `TMR8_BOTTOM;
         buf_a_q <= `TMR8_BOTTOM;
         buf_b_q <= `TMR8_BOTTOM;
      end else begin
         if (ca_wr) begin
            buf_a_q <= wb_dat_i[7:0];
         end
         if (cb_wr) begin
            buf_b_q <= wb_dat_i[7:0];
         end
         if (!pwm) begin
            // Direct access, buffer tracks the active value
            if (ca_wr) begin
               cmp_a_q <= wb_dat_i[7:0];
            end
            if (cb_wr) begin
               cmp_b_q <= wb_dat_i[7:0];
            end
         end else if (upd_pt) begin
            cmp_a_q <= buf_a_q;
            cmp_b_q <= buf_b_q;
         end
      end
   end

   // Control, mask and power registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_a_q <= 8'h00;
         ctrl_b_q <= 5'h00;
         mask_q <= 3'h0;
         power_off_q <= 1'b0;
      end else if (wr) begin
         if (idx == `TMR8_IDX_CTRL_A) begin
            ctrl_a_q <= wb_dat_i[7:0];
         end else if (idx == `TMR8_IDX_CTRL_B) begin
            ctrl_b_q <= wb_dat_i[4:0];
         end else if (idx == `TMR8_IDX_MASK) begin
            mask_q <= wb_dat_i[2:0];
         end else if (idx == `TMR8_IDX_POWER) begin
            power_off_q <= wb_dat_i[0];
         end
      end
   end

   // Flags: set wins over write-one clear and service clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= 3'h0;
      end else begin
         if (wr && idx == `TMR8_IDX_FLAGS) begin
            flag_q <= flag_q & ~wb_dat_i[2:0];
         end
         if (ovf_service_i) begin
            flag_q[`TMR8_F_OVF] <= 1'b0;
         end
         if (cmpa_service_i) begin
            flag_q[`TMR8_F_CMPA] <= 1'b0;
         end
         if (cmpb_service_i) begin
            flag_q[`TMR8_F_CMPB] <= 1'b0;
         end
         if (ovf_set) begin
            flag_q[`TMR8_F_OVF] <= 1'b1;
         end
         // Match seen at a tick sets the flag on that tick edge
         if (tick && match_a) begin
            flag_q[`TMR8_F_CMPA] <= 1'b1;
         end
         if (tick && match_b) begin
            flag_q[`TMR8_F_CMPB] <= 1'b1;
         end
      end
   end

   // Interrupt requests
   assign ovf_irq_o = flag_q[`TMR8_F_OVF] & mask_q[`TMR8_F_OVF];
   assign cmpa_irq_o = flag_q[`TMR8_F_CMPA] & mask_q[`TMR8_F_CMPA];
   assign cmpb_irq_o = flag_q[`TMR8_F_CMPB] & mask_q[`TMR8_F_CMPB];

   // Waveform action for one unit
   function wave_next;
      input cur;
      input [1:0] com;
      input hit;
      input is_pwm;
      input pc;
      input down;
      input at_bottom;
      begin
         wave_next = cur;
         if (com == `TMR8_COM_NONE) begin
            wave_next = cur;
         end else if (!is_pwm) begin
            if (hit) begin
               case (com)
                  `TMR8_COM_TOGGLE: wave_next = ~cur;
                  `TMR8_COM_CLEAR: wave_next = 1'b0;
                  default: wave_next = 1'b1;
               endcase
            end
         end else if (com != `TMR8_COM_TOGGLE) begin
            // Inverting when com is set mode; clear on up match, set at bottom in fast modes or on down match in phase correct
            if (hit) begin
               wave_next = (com == `TMR8_COM_SET) ^ (pc & down);
            end else if (at_bottom && !pc) begin
               wave_next = (com != `TMR8_COM_SET);
            end
         end
      end
   endfunction

   // Wave state: real matches on tick, forced strobes in non-PWM only
   always @(posedge clk_i) begin
      if (rst_i) begin
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
      end else begin
         if (wr && idx == `TMR8_IDX_CTRL_B && !pwm) begin
            wave_a_q <= wave_next(wave_a_q, ctrl_a_q[`TMR8_CA_COMA], wb_dat_i[`TMR8_CB_FOCA],
                                  1'b0, 1'b0, 1'b0, 1'b0);
            wave_b_q <= wave_next(wave_b_q, ctrl_a_q[`TMR8_CA_COMB], wb_dat_i[`TMR8_CB_FOCB],
                                  1'b0, 1'b0, 1'b0, 1'b0);
         end else if (tick) begin
            wave_a_q <= wave_next(wave_a_q, ctrl_a_q[`TMR8_CA_COMA], match_a, pwm, pc_mode,
                                  dir_down_q, is_bottom);
            wave_b_q <= wave_next(wave_b_q, ctrl_a_q[`TMR8_CA_COMB], match_b, pwm, pc_mode,
                                  dir_down_q, is_bottom);
         end
      end
   end

   assign wave_output_a_o = wave_a_q;
   assign wave_output_b_o = wave_b_q;
   // Pin override enables, low while the output drives the pin
   assign wave_a_en_o = (ctrl_a_q[`TMR8_CA_COMA] == `TMR8_COM_NONE);
   assign wave_b_en_o = (ctrl_a_q[`TMR8_CA_COMB] == `TMR8_COM_NONE);

   // Bus acknowledge and read data
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         ack_q <= req;
         if (req) begin
            if (idx == `TMR8_IDX_CTRL_A) begin
               wb_dat_o <= {24'h000000, ctrl_a_q};
            end else if (idx == `TMR8_IDX_CTRL_B) begin
               wb_dat_o <= {27'h0000000, ctrl_b_q};
            end else if (idx == `TMR8_IDX_COUNT) begin
               wb_dat_o <= {24'h000000, count_q};
            end else if (idx == `TMR8_IDX_CMP_A) begin
               wb_dat_o <= {24'h000000, pwm ? buf_a_q : cmp_a_q};
            end else if (idx == `TMR8_IDX_CMP_B) begin
               wb_dat_o <= {24'h000000, pwm ? buf_b_q : cmp_b_q};
            end else if (idx == `TMR8_IDX_FLAGS) begin
               wb_dat_o <= {29'h00000000, flag_q};
            end else if (idx == `TMR8_IDX_MASK) begin
               wb_dat_o <= {29'h00000000, mask_q};
            end else begin
               wb_dat_o <= {31'h00000000, power_off_q};
            end
         end
      end
   end

endmodule

//--- core/tmr8_consts.vh
// Constants for the 8-bit timer/counter with two compare units
`ifndef TMR8_CONSTS_VH
`define TMR8_CONSTS_VH
// Register word offsets (byte address = 4 * index)
`define TMR8_IDX_CTRL_A 3'h0
`define TMR8_IDX_CTRL_B 3'h1
`define TMR8_IDX_COUNT 3'h2
`define TMR8_IDX_CMP_A 3'h3
`define TMR8_IDX_CMP_B 3'h4
`define TMR8_IDX_FLAGS 3'h5
`define TMR8_IDX_MASK 3'h6
`define TMR8_IDX_POWER 3'h7
// Count extremes
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
`define TMR8_ONE 8'h01
// Control A fields
`define TMR8_CA_WGM_LO 1:0
`define TMR8_CA_COMB 5:4
`define TMR8_CA_COMA 7:6
// Control B fields
`define TMR8_CB_CS 2:0
`define TMR8_CB_WGM_HI 3
`define TMR8_CB_FOCB 6
`define TMR8_CB_FOCA 7
// Flag and mask bit positions
`define TMR8_F_OVF 0
`define TMR8_F_CMPA 1
`define TMR8_F_CMPB 2
// Waveform modes
`define TMR8_WGM_NORMAL 3'h0
`define TMR8_WGM_PC_MAX 3'h1
`define TMR8_WGM_CTC 3'h2
`define TMR8_WGM_FAST_MAX 3'h3
`define TMR8_WGM_PC_CMPA 3'h5
`define TMR8_WGM_FAST_CMPA 3'h7
// Clock selects
`define TMR8_CS_OFF 3'h0
`define TMR8_CS_DIV1 3'h1
`define TMR8_CS_DIV8 3'h2
`define TMR8_CS_DIV64 3'h3
`define TMR8_CS_DIV256 3'h4
`define TMR8_CS_DIV1024 3'h5
`define TMR8_CS_EXT_FALL 3'h6
// Compare output modes
`define TMR8_COM_NONE 2'h0
`define TMR8_COM_TOGGLE 2'h1
`define TMR8_COM_CLEAR 2'h2
`define TMR8_COM_SET 2'h3
// Prescaler width and taps
`define TMR8_PRE_W 10
`define TMR8_PRE_8 2:0
`define TMR8_PRE_64 5:0
`define TMR8_PRE_256 7:0
`define TMR8_PRE_1024 9:0
`endif

//--- testbench/tmr8_checker_assertions.sv
// Port-level checker for the 8-bit timer: bus handshake, reset state, wave outputs, masks
`include "tmr8_consts.vh"
module tmr8_checker (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [4:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire ovf_irq_o,
   input wire cmpa_irq_o,
   input wire cmpb_irq_o,
   input wire wave_output_a_o,
   input wire wave_output_b_o,
   input wire wave_a_en_o,
   input wire wave_b_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   // Request accepted at this edge
   wire take_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Accepted byte-lane writes to control A and to the mask
   wire wr_w = take_w && wb_we_i && wb_sel_i[0];
   wire ctla_wr_w = wr_w && (wb_adr_i[4:2] == `TMR8_IDX_CTRL_A);
   wire mask_wr_w = wr_w && (wb_adr_i[4:2] == `TMR8_IDX_MASK);
   AST_ACK_LATENCY: assert property (disable iff (rst_i) take_w |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   AST_ACK_PULSE: assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (disable iff (rst_i) wb_ack_o |-> $past(take_w))
      else $error("ack without request");
   AST_DAT_UPPER: assert property (disable iff (rst_i) wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   AST_RST_WAVE: assert property (rst_i |=> !wave_output_a_o && !wave_output_b_o)
      else $error("wave state not cleared by reset");
   AST_RST_OUT: assert property (rst_i |=> !ovf_irq_o && !cmpa_irq_o && !cmpb_irq_o &&
      wave_a_en_o && wave_b_en_o)
      else $error("outputs not cleared by reset");
   AST_EN_FOLLOW: assert property (disable iff (rst_i) ctla_wr_w |=>
      wave_a_en_o == ($past(wb_dat_i[7:6]) == 2'h0) && wave_b_en_o == ($past(wb_dat_i[5:4]) == 2'h0))
      else $error("pin enable does not follow output mode");
   AST_HOLD_A: assert property (disable iff (rst_i) wave_a_en_o |=> $stable(wave_output_a_o))
      else $error("wave a changed with output mode zero");
   AST_HOLD_B: assert property (disable iff (rst_i) wave_b_en_o |=> $stable(wave_output_b_o))
      else $error("wave b changed with output mode zero");
   AST_MASK_OFF: assert property (disable iff (rst_i) mask_wr_w && wb_dat_i[2:0] == 3'h0 |=>
      !ovf_irq_o && !cmpa_irq_o && !cmpb_irq_o)
      else $error("request seen with all masks off");
endmodule
bind tmr8_counter tmr8_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .ovf_irq_o(ovf_irq_o), .cmpa_irq_o(cmpa_irq_o), .cmpb_irq_o(cmpb_irq_o),
   .wave_output_a_o(wave_output_a_o), .wave_output_b_o(wave_output_b_o), .wave_a_en_o(wave_a_en_o),
   .wave_b_en_o(wave_b_en_o));

//--- testbench/tmr8_cpu_model.sv
// Processor core model: classic Wishbone master for the timer registers
module tmr8_cpu_model (
   input wire clk_i,
   input wire ack_i,
   input wire [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [4:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 5'h00;
      sel_o = 4'h0;
      dat_o = 32'h00000000;
   end
   // One classic cycle; request held until ack is sampled high or 40 edges pass
   task automatic access(input logic we, input logic [2:0] idx, input logic [7:0] wd, input logic s0,
         output logic [7:0] rd, output logic ok);
      int n;
      ok = 1'b0;
      rd = 8'h00;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= we;
      adr_o <= {idx, 2'b00};
      sel_o <= {3'b000, s0};
      dat_o <= {24'h000000, wd};
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge clk_i);
         if (ack_i === 1'b1) begin
            ok = 1'b1;
            rd = dat_i[7:0];
         end
      end
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      // Released data and address lines carry no stale value
      dat_o <= ~dat_o;
      adr_o <= ~adr_o;
   endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the 8-bit timer with two compare units
`include "tmr8_consts.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ext_i = 1'b0;
   logic [2:0] srv = 3'h0; // Service pulses: compare B, compare A, overflow
   wire cyc, stb, we, ack, ovf_irq, cmpa_irq, cmpb_irq, wave_a, wave_b, en_a, en_b;
   wire [4:0] adr;
   wire [3:0] sel;
   wire [31:0] wdat, rdat;
   wire [2:0] irqs = {cmpb_irq, cmpa_irq, ovf_irq};
   wire [7:0] pins = {4'h0, en_b, en_a, wave_b, wave_a};
   int bad_count = 0;
   int total_checks = 0;
   always #4 clk_i = ~clk_i;
   tmr8_counter dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_count_i(ext_i),
      .ovf_service_i(srv[0]), .cmpa_service_i(srv[1]), .cmpb_service_i(srv[2]), .ovf_irq_o(ovf_irq),
      .cmpa_irq_o(cmpa_irq), .cmpb_irq_o(cmpb_irq), .wave_output_a_o(wave_a), .wave_output_b_o(wave_b),
      .wave_a_en_o(en_a), .wave_b_en_o(en_b));
   tmr8_cpu_model cpu_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   // Verdict and end of run
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Expired wait counts as a mismatch
   task automatic expire;
      bad_count++;
      $display("Error wait expected done seen timeout");
      print_verdict();
   endtask
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] v);
      total_checks++;
      if (v !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, e, v);
      end
   endtask
   task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d, input logic s0,
         output logic [7:0] v);
      logic ok;
      cpu_u.access(w, idx, d, s0, v, ok);
      if (!ok) expire();
   endtask
   task automatic wr(input logic [2:0] idx, input logic [7:0] d);
      logic [7:0] v;
      bus(1'b1, idx, d, 1'b1, v);
   endtask
   task automatic rdc(input logic [2:0] idx, input logic [7:0] e, input string what);
      logic [7:0] v;
      bus(1'b0, idx, 8'h00, 1'b1, v);
      chk(what, e, v);
   endtask
   // Bounded wait for one request line
   task automatic wait_hi(input int k);
      int n;
      for (n = 0; n < 60 && irqs[k] !== 1'b1; n++) @(posedge clk_i);
      if (n == 60) expire();
   endtask
   task automatic t_reset;
      for (int i = 0; i < 8; i++) rdc(i[2:0], 8'h00, "reset value");
      chk("pins", 8'h0c, pins);
      $display("test reset done");
   endtask
   // Toggle on A, set on B, timer stopped
   task automatic t_force;
      wr(`TMR8_IDX_CTRL_A, 8'h70);
      wr(`TMR8_IDX_CTRL_B, 8'h80);
      wr(`TMR8_IDX_CTRL_B, 8'h40);
      rdc(`TMR8_IDX_FLAGS, 8'h00, "flags");
      rdc(`TMR8_IDX_COUNT, 8'h00, "count");
      chk("pins", 8'h03, pins);
      wr(`TMR8_IDX_CTRL_B, 8'h80);
      rdc(`TMR8_IDX_CTRL_B, 8'h00, "strobe read");
      chk("pins", 8'h02, pins);
      wr(`TMR8_IDX_CTRL_A, 8'h00);
      $display("test force done");
   endtask
   task automatic t_stop;
      logic [7:0] v;
      wr(`TMR8_IDX_COUNT, 8'h5a);
      bus(1'b1, `TMR8_IDX_COUNT, 8'h11, 1'b0, v);
      repeat (20) @(posedge clk_i);
      rdc(`TMR8_IDX_COUNT, 8'h5a, "stopped count");
      wr(`TMR8_IDX_POWER, 8'h01);
      wr(`TMR8_IDX_CTRL_B, 8'h01);
      repeat (20) @(posedge clk_i);
      rdc(`TMR8_IDX_COUNT, 8'h5a, "powered off count");
      wr(`TMR8_IDX_CTRL_B, 8'h00);
      wr(`TMR8_IDX_POWER, 8'h00);
      // Forty clock edges with the divide-by-eight select give exactly five ticks
      wr(`TMR8_IDX_COUNT, 8'h00);
      wr(`TMR8_IDX_CTRL_B, 8'h02);
      repeat (37) @(posedge clk_i);
      wr(`TMR8_IDX_CTRL_B, 8'h00);
      rdc(`TMR8_IDX_COUNT, 8'h05, "divided count");
      $display("test stop done");
   endtask
   // Three rising edges, then one falling edge, on the count pin
   task automatic t_ext;
      wr(`TMR8_IDX_COUNT, 8'h00);
      wr(`TMR8_IDX_CTRL_B, 8'h07);
      repeat (3) begin
         @(posedge clk_i);
         ext_i <= 1'b1;
         repeat (5) @(posedge clk_i);
         ext_i <= 1'b0;
         repeat (5) @(posedge clk_i);
      end
      wr(`TMR8_IDX_CTRL_B, 8'h06);
      @(posedge clk_i);
      ext_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rdc(`TMR8_IDX_COUNT, 8'h03, "count after rising edge");
      ext_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      wr(`TMR8_IDX_CTRL_B, 8'h00);
      rdc(`TMR8_IDX_COUNT, 8'h04, "external count");
      $display("test external done");
   endtask
   task automatic t_ovf;
      wr(`TMR8_IDX_CMP_A, 8'h80);
      wr(`TMR8_IDX_CMP_B, 8'h80);
      wr(`TMR8_IDX_COUNT, 8'hfc);
      wr(`TMR8_IDX_MASK, 8'h01);
      wr(`TMR8_IDX_CTRL_B, 8'h01);
      wait_hi(0);
      wr(`TMR8_IDX_CTRL_B, 8'h00);
      rdc(`TMR8_IDX_FLAGS, 8'h01, "overflow flag");
      wr(`TMR8_IDX_MASK, 8'h00);
      chk("irq masked", 8'h00, {5'h00, irqs});
      wr(`TMR8_IDX_MASK, 8'h07);
      chk("irq unmasked", 8'h01, {5'h00, irqs});
      wr(`TMR8_IDX_FLAGS, 8'h06);
      rdc(`TMR8_IDX_FLAGS, 8'h01, "flag after zero write");
      wr(`TMR8_IDX_FLAGS, 8'h01);
      rdc(`TMR8_IDX_FLAGS, 8'h00, "flag after one write");
      $display("test overflow done");
   endtask
   task automatic t_ctc;
      logic [7:0] v;
      wr(`TMR8_IDX_CMP_A, 8'h05);
      wr(`TMR8_IDX_COUNT, 8'h00);
      wr(`TMR8_IDX_CTRL_A, 8'h02);
      wr(`TMR8_IDX_CTRL_B, 8'h01);
      wait_hi(1);
      repeat (30) @(posedge clk_i);
      wr(`TMR8_IDX_CTRL_B, 8'h00);
      bus(1'b0, `TMR8_IDX_COUNT, 8'h00, 1'b1, v);
      chk("count within top", 8'h01, {7'h00, v <= 8'h05});
      @(posedge clk_i);
      srv <= 3'h2;
      @(posedge clk_i);
      srv <= 3'h0;
      rdc(`TMR8_IDX_FLAGS, 8'h00, "flag after service");
      wr(`TMR8_IDX_CTRL_A, 8'h00);
      $display("test clear on compare done");
   endtask
   task automatic t_block;
      wr(`TMR8_IDX_COUNT, 8'h80);
      wr(`TMR8_IDX_CTRL_B, 8'h01);
      wr(`TMR8_IDX_CTRL_B, 8'h00);
      rdc(`TMR8_IDX_FLAGS, 8'h00, "blocked match");
      wr(`TMR8_IDX_COUNT, 8'h7e);
      wr(`TMR8_IDX_CTRL_B, 8'h01);
      repeat (10) @(posedge clk_i);
      wr(`TMR8_IDX_CTRL_B, 8'h00);
      rdc(`TMR8_IDX_FLAGS, 8'h04, "compare b flag");
      chk("compare b irq", 8'h04, {5'h00, irqs});
      @(posedge clk_i);
      srv <= 3'h4;
      @(posedge clk_i);
      srv <= 3'h0;
      rdc(`TMR8_IDX_FLAGS, 8'h00, "flag b after service");
      $display("test match blocking done");
   endtask
   // Compare B buffered in fast PWM; the active copy is loaded at top only
   task automatic t_pwm;
      wr(`TMR8_IDX_CMP_B, 8'h10);
      wr(`TMR8_IDX_CTRL_A, 8'h03);
      wr(`TMR8_IDX_CMP_B, 8'h20);
      rdc(`TMR8_IDX_CMP_B, 8'h20, "buffer read");
      // Count passes 0x20 but the active value is still 0x10
      wr(`TMR8_IDX_COUNT, 8'h18);
      wr(`TMR8_IDX_CTRL_B, 8'h01);
      repeat (10) @(posedge clk_i);
      wr(`TMR8_IDX_CTRL_B, 8'h00);
      rdc(`TMR8_IDX_FLAGS, 8'h00, "no match before top");
      // Twenty-six ticks from 0xfe: wrap at top loads 0x20, count stops at 0x18
      wr(`TMR8_IDX_COUNT, 8'hfe);
      wr(`TMR8_IDX_CTRL_B, 8'h01);
      repeat (23) @(posedge clk_i);
      wr(`TMR8_IDX_CTRL_B, 8'h00);
      rdc(`TMR8_IDX_COUNT, 8'h18, "count after wrap");
      rdc(`TMR8_IDX_FLAGS, 8'h03, "flags after top update");
      @(posedge clk_i);
      srv <= 3'h3;
      @(posedge clk_i);
      srv <= 3'h0;
      rdc(`TMR8_IDX_FLAGS, 8'h00, "flags after service");
      wr(`TMR8_IDX_CTRL_A, 8'h00);
      $display("test buffered compare done");
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_force();
      t_stop();
      t_ext();
      t_ovf();
      t_ctc();
      t_block();
      t_pwm();
      print_verdict();
   end
endmodule
